// ### verilog/sl_params.svh
`ifndef SL_PARAMS_SVH
`define SL_PARAMS_SVH
// Flash window and password limits
`define SL_FLASH_LO  16'hc000
`define SL_FLASH_HI  16'hffff
`define SL_PW_HI     16'hff9f
`define SL_PW_LIM    16'hffa0
`define SL_BLANK_LO  16'hffe0
`define SL_ERASED    8'hff
`define SL_PW_MIN    8'h08
// Hex record fields
`define SL_MARK      8'h3a
`define SL_REC_DATA  8'h00
`define SL_REC_END   8'h01
`define SL_REC_EXT   8'h02
`define SL_EXT_LEN   8'h02
`define SL_EXT_LIM   16'h1000
// Response frames
`define SL_ID_CNT    8'h0a
`define SL_ADDR_LEN  8'h02
`define SL_ROM_BLKS  8'h01
`define SL_ST_CNT    8'h04
`define SL_ID_LAST   4'hc
`define SL_ST_LAST   4'h6
`define SL_SUM_LAST  4'h1
`define SL_CK_FIRST  4'h2
`define SL_ID_CK_HI  4'hb
`define SL_ST_CK_HI  4'h5
`endif

// ### verilog/sl_pkg.sv
`default_nettype none
package sl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PWRX  = 4'h1,
    ST_BLANK = 4'h2,
    ST_CNT   = 4'h3,
    ST_PWCMP = 4'h4,
    ST_HEX   = 4'h5,
    ST_SUM   = 4'h6,
    ST_SUMTX = 4'h7,
    ST_IDTX  = 4'h8,
    ST_STTX  = 4'h9,
    ST_HALT  = 4'ha
  } sl_state_t;
  typedef enum logic [2:0] {
    HF_MARK = 3'h0,
    HF_LEN  = 3'h1,
    HF_AH   = 3'h2,
    HF_AL   = 3'h3,
    HF_TYPE = 3'h4,
    HF_DATA = 3'h5,
    HF_CKS  = 3'h6
  } sl_hex_t;
  typedef enum logic [2:0] {
    MD_WRITE = 3'h0,
    MD_RAM   = 3'h1,
    MD_SUM   = 3'h2,
    MD_ID    = 3'h3,
    MD_STAT  = 3'h4,
    MD_ERASE = 3'h5
  } sl_mode_t;
endpackage
`default_nettype wire

// ### verilog/sl_sum_acc.sv
`default_nettype none
module sl_sum_acc (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Byte input
  input  wire logic        clr_i,
  input  wire logic        add_i,
  input  wire logic [7:0]  byte_i,
  // Running sum
  output logic      [15:0] sum_o
);
  // Bytes add one at a time; carries past bit 15 simply fall off
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sum_o <= 16'h0000;
    end else if (clr_i) begin
      sum_o <= 16'h0000;
    end else if (add_i) begin
      sum_o <= sum_o + {8'h00, byte_i};
    end
  end

  a_sum_wrap: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (add_i && !clr_i) |=> sum_o == 16'($past(sum_o) + {8'h00, $past(byte_i)}))
    else $error("checksum did not add the byte modulo 65536");
endmodule
`default_nettype wire

// ### verilog/sl_tx_buf.sv
`default_nettype none
module sl_tx_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  logic         skid_v_q;
  logic [W-1:0] skid_d_q;

  // Full when the skid slot holds a word; a stalled receiver loses nothing
  assign in_ready_o = !skid_v_q;

  // Output stage first, skid slot catches a word while the output stalls
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      skid_v_q    <= 1'b0;
      skid_d_q    <= '0;
    end else if (!out_valid_o || out_ready_i) begin
      if (skid_v_q) begin
        out_data_o <= skid_d_q;
        out_valid_o <= 1'b1;
        skid_v_q <= 1'b0;
      end else begin
        out_valid_o <= in_valid_i;
        if (in_valid_i) begin
          out_data_o <= in_data_i;
        end
      end
    end else if (in_valid_i && !skid_v_q) begin
      skid_v_q <= 1'b1;
      skid_d_q <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### verilog/sl_loader.sv
`default_nettype none
`include "sl_params.svh"
// Operation
// - Checksum adds every covered byte singly; reported as upper and lower byte.
// - Flash write and sum modes sum the whole flash from C000H.
// - Record length, address, type and checksum never enter the sum.
// - RAM loading sums from first to last received RAM address.
// - ID and status responses checksum their own transferred bytes.
// - Erase sums erased sectors, or the whole flash after chip erase.
// - After a record checksum, only a 3AH mark starts the next record.
// - Receive or format errors halt silently.
// - Unknown record type or bad record checksum is a format error.
// - Extended length not 02H, or data after extended address >=1000H, errors.
// - End record with nonzero length is a format error.
// - Password lies in C000H..FF9FH, at least eight bytes.
// - All FFH at FFE0H..FFFFH means blank: no compare, addresses still taken.
// - Count address out of range, count below 8, or late start errors.
// - Three identical consecutive password bytes halt silently.
// - Password mismatch halts until reset.
// - Blank part expects records right after compare start; dummy 3AH misparses.
// - ID response is thirteen fixed-order bytes with count 0AH.
// - Last ID byte is two's complement of bytes 3 to 12.
module sl_loader #(
  parameter logic [7:0] ID_RSV0 = 8'h5a // Arbitrary reserved identity byte
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Command
  input  wire logic             start_i,
  input  wire sl_pkg::sl_mode_t mode_i,
  input  wire logic [1:0]       status_code_i,
  input  wire logic [15:0]      erase_start_i,
  input  wire logic [15:0]      erase_end_i,
  // Receive bytes
  input  wire logic             rx_valid_i,
  input  wire logic [7:0]       rx_data_i,
  input  wire logic             rx_err_i,
  // Transmit bytes
  output logic                  tx_valid_o,
  output logic      [7:0]       tx_data_o,
  input  wire logic             tx_ready_i,
  // Memory port
  output logic      [15:0]      mem_addr_o,
  output logic                  mem_rd_o,
  input  wire logic [7:0]       mem_rdata_i,
  output logic                  mem_we_o,
  output logic      [7:0]       mem_wdata_o,
  // Status
  output logic                  busy_o,
  output logic                  halt_o
);
  import sl_pkg::*;

  sl_state_t   st_q;
  sl_hex_t     hf_q;
  sl_mode_t    md_q;
  logic [7:0]  rxb_q, len_q, rsum_q, rtype_q, cnt_q, pwb_q, p1_q, p2_q;
  logic [15:0] cur_q, end_q, password_count_location_q, password_compare_start_q, raddr_q, ext_q, first_q, last_q;
  logic [3:0]  idx_q;
  logic [1:0]  pwn_q;
  logic        rxv_q, dv_q, blank_q, have_q, extbig_q, gotfirst_q;
  logic        take, rd_req, wr_now, fail, push, tx_rdy, acc_clr, acc_en;
  logic [7:0]  push_d, acc_b;
  logic [15:0] acc_sum, er_lo, er_hi;
  logic        blank_now;

  // Password area check, used for both address fields
  function automatic logic pw_ok(input logic [15:0] a);
    pw_ok = (a >= `SL_FLASH_LO) && (a <= `SL_PW_HI);
  endfunction

  // Byte of an outgoing frame
  function automatic logic [7:0] frame_byte(input sl_state_t s, input logic [3:0] i,
                                            input logic [1:0] code, input logic [15:0] sm);
    frame_byte = 8'h00;
    case (s)
      ST_SUMTX: frame_byte = (i == 4'h0) ? sm[15:8] : sm[7:0];
      ST_IDTX: begin
        case (i)
          4'h0: frame_byte = `SL_MARK;
          4'h1: frame_byte = `SL_ID_CNT;
          4'h2: frame_byte = `SL_ADDR_LEN;
          4'h3: frame_byte = ID_RSV0;
          4'h7: frame_byte = `SL_ROM_BLKS;
          4'h8: frame_byte = 8'(`SL_FLASH_LO >> 8);
          4'h9: frame_byte = 8'(`SL_FLASH_LO);
          4'ha: frame_byte = 8'(`SL_FLASH_HI >> 8);
          4'hb: frame_byte = 8'(`SL_FLASH_HI);
          4'hc: frame_byte = 8'h00 - sm[7:0];
          default: frame_byte = 8'h00;
        endcase
      end
      ST_STTX: begin
        case (i)
          4'h0: frame_byte = `SL_MARK;
          4'h1: frame_byte = `SL_ST_CNT;
          4'h2: frame_byte = {6'h00, code};
          4'h6: frame_byte = 8'h00 - sm[7:0];
          default: frame_byte = 8'h00;
        endcase
      end
      default: frame_byte = 8'h00;
    endcase
  endfunction

  // Chip erase when start lies above end, else the named sectors only
  assign er_lo = (erase_start_i > erase_end_i) ? `SL_FLASH_LO : erase_start_i;
  assign er_hi = (erase_start_i > erase_end_i) ? `SL_FLASH_HI : erase_end_i;

  // Byte consumption and silent error detection
  always_comb begin
    take = rxv_q && (st_q == ST_PWRX || st_q == ST_HEX || (st_q == ST_PWCMP && !have_q));
    fail = (st_q != ST_IDLE) && (st_q != ST_HALT) && rx_valid_i
           && (rx_err_i || (rxv_q && !take));
    rd_req = !mem_rd_o && !dv_q && (st_q == ST_BLANK || st_q == ST_CNT
             || st_q == ST_SUM || (st_q == ST_PWCMP && have_q));
    wr_now = take && st_q == ST_HEX && hf_q == HF_DATA && rtype_q == `SL_REC_DATA;
    blank_now = blank_q && (mem_rdata_i == `SL_ERASED);
  end

  // Transmit pushes and checksum feed
  always_comb begin
    push = tx_rdy && (st_q == ST_SUMTX || st_q == ST_IDTX || st_q == ST_STTX);
    push_d = frame_byte(st_q, idx_q, status_code_i, acc_sum);
    acc_clr = (st_q == ST_IDLE) && start_i;
    acc_en = 1'b0;
    acc_b = push_d;
    if (st_q == ST_SUM && dv_q) begin
      acc_en = 1'b1;
      acc_b = mem_rdata_i;
    end else if (push && idx_q >= `SL_CK_FIRST) begin
      acc_en = (st_q == ST_IDTX) ? (idx_q <= `SL_ID_CK_HI)
             : (st_q == ST_STTX) && (idx_q <= `SL_ST_CK_HI);
    end
  end

  // One byte held from the receiver; a second before it is used is an overrun
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rxv_q <= 1'b0;
      rxb_q <= 8'h00;
    end else if (rx_valid_i && !rx_err_i) begin
      rxv_q <= 1'b1;
      rxb_q <= rx_data_i;
    end else if (take) begin
      rxv_q <= 1'b0;
    end
  end

  // Memory port; read data are valid the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_rd_o <= 1'b0;
      mem_we_o <= 1'b0;
      dv_q <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_rd_o <= rd_req;
      dv_q <= mem_rd_o;
      mem_we_o <= wr_now;
      mem_wdata_o <= rxb_q;
      mem_addr_o <= wr_now ? raddr_q : cur_q;
    end
  end

  // Status flags
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
      halt_o <= 1'b0;
    end else begin
      busy_o <= (st_q != ST_IDLE) && (st_q != ST_HALT);
      halt_o <= (st_q == ST_HALT);
    end
  end

  // Sequencer: password phase, record parsing, sums and frames
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      hf_q <= HF_MARK;
      md_q <= MD_WRITE;
      {len_q, rsum_q, rtype_q, cnt_q, pwb_q, p1_q, p2_q} <= '0;
      {cur_q, end_q, password_count_location_q, password_compare_start_q, raddr_q, ext_q, first_q, last_q} <= '0;
      idx_q <= 4'h0;
      pwn_q <= 2'h0;
      {blank_q, have_q, extbig_q, gotfirst_q} <= 4'h0;
    end else if (fail) begin
      st_q <= ST_HALT;
    end else begin
      case (st_q)
        ST_IDLE: if (start_i) begin
          md_q <= mode_i;
          {idx_q, cnt_q, pwn_q} <= '0;
          {blank_q, have_q, extbig_q, gotfirst_q} <= 4'h8;
          {first_q, last_q, ext_q} <= '0;
          cur_q <= `SL_FLASH_LO;
          end_q <= `SL_FLASH_HI;
          case (mode_i)
            MD_SUM: st_q <= ST_SUM;
            MD_ID: st_q <= ST_IDTX;
            MD_STAT: st_q <= ST_STTX;
            MD_WRITE, MD_RAM, MD_ERASE: st_q <= ST_PWRX;
            default: st_q <= ST_HALT;
          endcase
        end
        ST_PWRX: if (take) begin
          {password_count_location_q, password_compare_start_q} <= {password_count_location_q[7:0], password_compare_start_q, rxb_q};
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'h03) begin
            cur_q <= `SL_BLANK_LO;
            st_q <= ST_BLANK;
          end
        end
        ST_BLANK: if (dv_q) begin
          blank_q <= blank_now;
          if (cur_q != `SL_FLASH_HI) begin
            cur_q <= cur_q + 16'h0001;
          end else if (!pw_ok(password_count_location_q)) begin
            st_q <= ST_HALT;
          end else if (!blank_now) begin
            cur_q <= password_count_location_q;
            st_q <= ST_CNT;
          end else if (!pw_ok(password_compare_start_q)) begin
            st_q <= ST_HALT;
          end else begin
            st_q <= (md_q == MD_ERASE) ? ST_SUM : ST_HEX;
            {cur_q, end_q} <= {er_lo, er_hi};
            hf_q <= HF_MARK;
          end
        end
        ST_CNT: if (dv_q) begin
          if (mem_rdata_i < `SL_PW_MIN || !pw_ok(password_compare_start_q)
              || password_compare_start_q > (`SL_PW_LIM - {8'h00, mem_rdata_i})) begin
            st_q <= ST_HALT;
          end else begin
            cnt_q <= mem_rdata_i;
            cur_q <= password_compare_start_q;
            st_q <= ST_PWCMP;
          end
        end
        ST_PWCMP: begin
          if (take) begin
            if (pwn_q == 2'h2 && rxb_q == p1_q && p1_q == p2_q) begin
              st_q <= ST_HALT;
            end
            {p2_q, p1_q, pwb_q} <= {p1_q, rxb_q, rxb_q};
            pwn_q <= (pwn_q == 2'h2) ? pwn_q : pwn_q + 2'h1;
            have_q <= 1'b1;
          end else if (dv_q) begin
            have_q <= 1'b0;
            cur_q <= cur_q + 16'h0001;
            cnt_q <= cnt_q - 8'h01;
            if (mem_rdata_i != pwb_q) begin
              st_q <= ST_HALT;
            end else if (cnt_q == 8'h01) begin
              st_q <= (md_q == MD_ERASE) ? ST_SUM : ST_HEX;
              {cur_q, end_q} <= {er_lo, er_hi};
              hf_q <= HF_MARK;
            end
          end
        end
        ST_HEX: if (take) begin
          rsum_q <= rsum_q + rxb_q;
          case (hf_q)
            HF_MARK: begin
              rsum_q <= 8'h00;
              if (rxb_q == `SL_MARK) begin
                hf_q <= HF_LEN;
              end
            end
            HF_LEN: begin
              len_q <= rxb_q;
              hf_q <= HF_AH;
            end
            HF_AH: begin
              raddr_q[15:8] <= rxb_q;
              hf_q <= HF_AL;
            end
            HF_AL: begin
              raddr_q[7:0] <= rxb_q;
              hf_q <= HF_TYPE;
            end
            HF_TYPE: begin
              rtype_q <= rxb_q;
              hf_q <= (len_q == 8'h00) ? HF_CKS : HF_DATA;
              if (rxb_q > `SL_REC_EXT) begin
                st_q <= ST_HALT;
              end else if (rxb_q == `SL_REC_EXT && len_q != `SL_EXT_LEN) begin
                st_q <= ST_HALT;
              end else if (rxb_q == `SL_REC_END && len_q != 8'h00) begin
                st_q <= ST_HALT;
              end else if (rxb_q == `SL_REC_DATA && extbig_q) begin
                st_q <= ST_HALT;
              end
            end
            HF_DATA: begin
              len_q <= len_q - 8'h01;
              if (len_q == 8'h01) begin
                hf_q <= HF_CKS;
              end
              if (rtype_q == `SL_REC_EXT) begin
                ext_q <= {ext_q[7:0], rxb_q};
              end
              if (wr_now) begin
                raddr_q <= raddr_q + 16'h0001;
                last_q <= raddr_q;
                gotfirst_q <= 1'b1;
                if (!gotfirst_q) begin
                  first_q <= raddr_q;
                end
              end
            end
            HF_CKS: begin
              hf_q <= HF_MARK;
              if (rsum_q + rxb_q != 8'h00) begin
                st_q <= ST_HALT;
              end else if (rtype_q == `SL_REC_EXT) begin
                extbig_q <= (ext_q >= `SL_EXT_LIM);
              end else if (rtype_q == `SL_REC_END) begin
                st_q <= ST_SUM;
                cur_q <= (md_q == MD_RAM) ? first_q : `SL_FLASH_LO;
                end_q <= (md_q == MD_RAM) ? last_q : `SL_FLASH_HI;
              end
            end
            default: hf_q <= HF_MARK;
          endcase
        end
        ST_SUM: if (dv_q) begin
          if (cur_q == end_q) begin
            st_q <= ST_SUMTX;
            idx_q <= 4'h0;
          end else begin
            cur_q <= cur_q + 16'h0001;
          end
        end
        ST_SUMTX, ST_IDTX, ST_STTX: if (push) begin
          idx_q <= idx_q + 4'h1;
          if ((st_q == ST_SUMTX && idx_q == `SL_SUM_LAST)
              || (st_q == ST_IDTX && idx_q == `SL_ID_LAST)
              || (st_q == ST_STTX && idx_q == `SL_ST_LAST)) begin
            st_q <= ST_IDLE;
            idx_q <= 4'h0;
          end
        end
        ST_HALT: st_q <= ST_HALT;
        default: st_q <= ST_HALT;
      endcase
    end
  end

  sl_sum_acc u_acc (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clr_i     (acc_clr),
    .add_i     (acc_en),
    .byte_i    (acc_b),
    .sum_o     (acc_sum)
  );

  // Frames pass a two-word buffer; a stalled receiver stalls the sequencer
  sl_tx_buf #(.W(8)) u_txb (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push),
    .in_data_i   (push_d),
    .in_ready_o  (tx_rdy),
    .out_valid_o (tx_valid_o),
    .out_data_o  (tx_data_o),
    .out_ready_i (tx_ready_i)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_halt_sticky: assert property (halt_o |=> halt_o)
    else $error("halt released without reset");
  a_rxerr_halt: assert property (fail |=> st_q == ST_HALT ##1 halt_o)
    else $error("receive error did not halt");
  a_bad_type: assert property (take && st_q == ST_HEX && hf_q == HF_TYPE
    && rxb_q > `SL_REC_EXT |=> st_q == ST_HALT)
    else $error("unknown record type accepted");
  a_mark_wait: assert property (take && st_q == ST_HEX && hf_q == HF_MARK && !fail
    && rxb_q != `SL_MARK |=> hf_q == HF_MARK)
    else $error("record started without mark");
  a_id_count: assert property (push && st_q == ST_IDTX && idx_q == 4'h1
    |-> push_d == `SL_ID_CNT)
    else $error("identification count byte wrong");
  // Checked against the fixed frame contents, so a broken accumulator path shows up
  a_id_cks: assert property (push && st_q == ST_IDTX && idx_q == `SL_ID_LAST
    |-> 8'(push_d + `SL_ADDR_LEN + ID_RSV0 + `SL_ROM_BLKS + 8'(`SL_FLASH_LO >> 8)
    + 8'(`SL_FLASH_HI >> 8) + 8'(`SL_FLASH_HI)) == 8'h00)
    else $error("identification checksum wrong");
  a_flash_span: assert property (st_q != ST_SUM ##1 st_q == ST_SUM && md_q != MD_RAM
    && md_q != MD_ERASE |-> cur_q == `SL_FLASH_LO && end_q == `SL_FLASH_HI)
    else $error("flash sum does not span whole array");
  a_pw_count: assert property (st_q == ST_CNT && dv_q && !fail
    && mem_rdata_i < `SL_PW_MIN |=> st_q == ST_HALT)
    else $error("short password accepted");
  a_pw_triple: assert property (take && st_q == ST_PWCMP && pwn_q == 2'h2
    && rxb_q == p1_q && p1_q == p2_q |=> ##1 halt_o)
    else $error("repeated password bytes accepted");

  c_halt: cover property (st_q == ST_PWCMP ##1 st_q == ST_HALT);
  c_sum_sent: cover property (push && st_q == ST_SUMTX && idx_q == `SL_SUM_LAST);
  c_id_sent: cover property (push && st_q == ST_IDTX && idx_q == `SL_ID_LAST);
endmodule
`default_nettype wire

// ### sim/sl_ctrl_model.sv
`default_nettype none
module sl_ctrl_model (
  // Clock and stall wish
  input  wire logic       sys_clk_i,
  input  wire logic       stall_i,
  // Byte link to the loader
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got_q[$];
  // Idle link at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
  end
  // Stalls come from the bench so the two-entry buffer must hold its words
  always @(negedge sys_clk_i) tx_ready_o <= !stall_i;
  // Every taken byte is queued for the bench
  always @(posedge sys_clk_i) if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
  // One-cycle strobe, then a gap; idle data is inverted so a stale byte never matches
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk_i);
    rx_data_o  <= b;
    rx_valid_o <= 1'b1;
    @(negedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
    repeat (3) @(negedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none
module tb_top;
  import sl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_BYTE4 = 8'h3c; // Arbitrary reserved identity value
  // Design and link signals
  logic        sys_clk_i, reset_n_i, start_i, rx_err_i, rxv, txv, txr;
  logic        stall = 1'b0;
  logic        mem_rd, mem_we, busy, halt;
  sl_mode_t    mode;
  logic [1:0]  code;
  logic [7:0]  rxd, txd, wdata;
  logic [7:0]  rdata = 8'h00;
  logic [15:0] addr, er_s, er_e;
  // Memory behind the loader and the bench's own copy of it
  logic [7:0]  mem [0:65535];
  int          ref_m [0:65535];
  int          exp_q[$];
  int          et[$];
  int          fail_count, compares, s;
  logic [31:0] rng = 32'h0000002f;

  sl_loader #(.ID_RSV0(ID_BYTE4)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .start_i(start_i), .mode_i(mode), .status_code_i(code), .erase_start_i(er_s),
    .erase_end_i(er_e), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_err_i(rx_err_i),
    .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .mem_addr_o(addr),
    .mem_rd_o(mem_rd), .mem_rdata_i(rdata), .mem_we_o(mem_we), .mem_wdata_o(wdata),
    .busy_o(busy), .halt_o(halt));
  sl_ctrl_model ctl (.sys_clk_i(sys_clk_i), .stall_i(stall), .rx_valid_o(rxv),
    .rx_data_o(rxd), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(txr));

  // 20 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Receiver stalls a quarter of the time
  always @(negedge sys_clk_i) stall <= (xs() % 4) == 0;
  // One-cycle read latency; data is scrambled outside its valid cycle
  always @(posedge sys_clk_i) begin
    rdata <= mem_rd ? mem[addr] : ~rdata;
    if (mem_we) mem[addr] <= wdata;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic end_of_test();
    $display("Counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset();
    reset_n_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    ctl.got_q.delete();
  endtask
  task automatic cmd(input sl_mode_t m);
    @(negedge sys_clk_i);
    mode    = m;
    start_i = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
  endtask
  // Values above 255 go out flagged as receive errors; the gap is shorter than the blank scan, so one held byte bridges it
  task automatic send1(input int v);
    rx_err_i = v > 255;
    ctl.send(v[7:0]);
    rx_err_i = 1'b0;
    repeat (70) @(negedge sys_clk_i);
  endtask
  task automatic send_list(input int q[$]);
    foreach (q[i]) send1(q[i]);
  endtask
  function automatic int rsum(input int lo, input int hi);
    int a;
    a = 0;
    for (int i = lo; i <= hi; i++) a += ref_m[i];
    return a & 65535;
  endfunction
  task automatic expect_frame(input string name);
    int n;
    n = 0;
    // A whole-flash sum takes three cycles a byte, close to 50000 cycles
    while ((ctl.got_q.size() < exp_q.size() || busy !== 1'b0) && n < 60000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 60000) begin
      fail_count++;
      end_of_test();
    end else begin
      chk(16'(ctl.got_q.size()), 16'(exp_q.size()));
      while (exp_q.size() > 0 && ctl.got_q.size() > 0)
        chk(16'(ctl.got_q.pop_front()), 16'(exp_q.pop_front()));
      exp_q.delete();
      ctl.got_q.delete();
      $display("Test %s done", name);
    end
  endtask
  // Blank part: password addresses, one data record, stray bytes, end record, sum back
  task automatic load(input sl_mode_t m, input int base, input int lo, input int hi);
    int ck;
    ck = 2 + base[15:8] + base[7:0] + 8'haa + 8'hbb;
    cmd(m);
    send_list('{8'hc0, 8'h00, 8'hc0, 8'h01});
    send_list('{8'h3a, 8'h02, base[15:8], base[7:0], 8'h00, 8'haa, 8'hbb, (-ck) & 255,
                8'h55, 8'h10});
    send_list('{8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
    ref_m[base] = 8'haa;
    ref_m[base + 1] = 8'hbb;
    s = rsum(lo, hi);
    exp_q = '{s >> 8, s & 255};
    expect_frame("load");
  endtask

  initial begin
    start_i = 1'b0;
    rx_err_i = 1'b0;
    mode = MD_ID;
    code = 2'h0;
    er_s = 16'hc000;
    er_e = 16'hc0ff;
    fail_count = 0;
    compares = 0;
    reset_n_i = 1'b0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = (i >= 32'h0000ffe0) ? 8'hff : 8'(xs());
      ref_m[i] = mem[i];
    end
    do_reset();
    cmd(MD_ID);
    exp_q = '{8'h3a, 8'h0a, 8'h02, ID_BYTE4, 8'h00, 8'h00, 8'h00, 8'h01, 8'hc0, 8'h00,
              8'hff, 8'hff};
    s = 0;
    foreach (exp_q[i]) if (i >= 2) s += exp_q[i];
    exp_q.push_back((-s) & 255);
    expect_frame("id");
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      cmd(MD_STAT);
      exp_q = '{8'h3a, 8'h04, c, 8'h00, 8'h00, 8'h00, (-c) & 255};
      expect_frame("status");
    end
    cmd(MD_SUM);
    s = rsum(32'h0000c000, 32'h0000ffff);
    exp_q = '{s >> 8, s & 255};
    expect_frame("sum");
    load(MD_RAM, 32'h00000100, 32'h00000100, 32'h00000101);
    load(MD_WRITE, 32'h0000c010, 32'h0000c000, 32'h0000ffff);
    // Sector erase on a blank part: no password string, sum over the erase range only
    cmd(MD_ERASE);
    send_list('{8'hc0, 8'h00, 8'hc0, 8'h01});
    s = rsum(32'h0000c000, 32'h0000c0ff);
    exp_q = '{s >> 8, s & 255};
    expect_frame("erase");
    // Faulty streams; -4 sends blank addresses; -2, -3 and -5 (count 7) make it non-blank
    et = '{-4, 8'h3a, 8'h00, 8'h00, 8'h00, 8'h03, 8'hfd, -1,
           -4, 8'h3a, 8'h01, 8'hc0, 8'h20, 8'h00, 8'h11, 8'h00, -1,
           -4, 8'h3a, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'hfd, -1,
           -4, 8'h3a, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'hfe, -1,
           -4, 8'h3a, 8'h02, 8'h00, 8'h00, 8'h02, 8'h10, 8'h00, 8'hec,
           8'h3a, 8'h01, 8'hc0, 8'h30, 8'h00, 8'h11, 8'hfe, -1,
           8'h00, 8'h10, 8'hc0, 8'h01, -1, -4, 32'h0000013a, -1,
           -2, 8'hf0, 8'h00, 8'hf0, 8'h01, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
           8'h17, 8'h19, -1, -3, 8'hf0, 8'h00, 8'hf0, 8'h01, 8'h22, 8'h22, 8'h22, -1,
           -2, 8'hf0, 8'h00, 8'hff, 8'h9a, -1, -5, 8'hf0, 8'h00, 8'hf0, 8'h01, -1};
    while (et.size() > 0) begin
      do_reset();
      cmd(MD_WRITE);
      while (et[0] != -1) begin
        if (et[0] == -4) send_list('{8'hc0, 8'h00, 8'hc0, 8'h01});
        else if (et[0] < -1) begin
          mem[16'hffff] = 8'h00;
          mem[16'hf000] = (et[0] == -5) ? 8'h07 : 8'h08;
          for (int k = 1; k <= 8; k++)
            mem[16'hf000 + k] = (et[0] != -3) ? 8'(8'h10 + k) : ((k < 4) ? 8'h22 : 8'(8'h20 + k));
        end else send1(et[0]);
        void'(et.pop_front());
      end
      void'(et.pop_front());
      for (int n = 0; n < 200 && halt !== 1'b1; n++) @(negedge sys_clk_i);
      chk({15'h0000, halt}, 16'h0001);
      chk(16'(ctl.got_q.size()), 16'h0000);
      $display("Test fault stream done");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
